//--- ocs_cfg.svh
// constants for the overcurrent stage timing block: offsets, fields, resets, timing
// assumes a 25 ns system clock and a 5 ms program cycle
`ifndef OCS_CFG_SVH
`define OCS_CFG_SVH

`define OCS_CLK_PERIOD_NS 25
`define OCS_TICK_MS 5
`define OCS_TICK_CYCLES (`OCS_TICK_MS * 1000000 / `OCS_CLK_PERIOD_NS)
`define OCS_REL_DELAY_MS 60
`define OCS_REL_DELAY_RST 16'(`OCS_REL_DELAY_MS / `OCS_TICK_MS)

// register map: four stages at a 32-byte stride, one global word
`define OCS_REG_CTRL 5'h00
`define OCS_REG_THRESH 5'h04
`define OCS_REG_RELEASE 5'h08
`define OCS_REG_OPDELAY 5'h0C
`define OCS_REG_TIMEDIAL 5'h10
`define OCS_REG_STATUS 5'h14
`define OCS_REG_GLOBAL 8'h80

// control word fields
`define OCS_CTRL_DLY_REL 1
`define OCS_CTRL_RST_AFTER 2
`define OCS_CTRL_CONT 3
`define OCS_CTRL_MAG_LSB 4
`define OCS_CTRL_BUS_ALLOW 6
`define OCS_CTRL_LOGINV 7
`define OCS_CTRL_FORCE_LSB 8
`define OCS_CTRL_MASK 32'h0000_1FFE

// reset values
`define OCS_CTRL_RST 32'h0000_0006
`define OCS_THRESH_RST 16'h04B0
`define OCS_OPDELAY_RST 16'h0014
`define OCS_TIMEDIAL_RST 16'h0064
`define OCS_TIMEDIAL_MIN 16'h001E
// drop-out ratio 97 over 100
`define OCS_RESET_RATIO 7'h61
`define OCS_RATIO_BASE 7'h64

`endif

//--- ocs_pkg.sv
// types shared by the overcurrent stage timing block
// assumes ocs_cfg.svh carries all numeric constants
package ocs_pkg;

  typedef enum logic [1:0] {
    OCS_MAG_RMS = 2'b00,
    OCS_MAG_TRUE_ROOT_MEAN_SQUARE = 2'b01,
    OCS_MAG_PP = 2'b10
  } ocs_mag_t;

  typedef enum logic [1:0] {
    OCS_ST_IDLE = 2'b00,
    OCS_ST_RUN = 2'b01,
    OCS_ST_RELEASE = 2'b10,
    OCS_ST_BLOCKED = 2'b11
  } ocs_tmr_st_t;

  typedef enum logic [4:0] {
    OCS_F_NORMAL = 5'h00,
    OCS_F_START = 5'h01,
    OCS_F_TRIP = 5'h02,
    OCS_F_BLOCKED = 5'h03,
    OCS_F_START_A = 5'h04,
    OCS_F_START_B = 5'h05,
    OCS_F_START_C = 5'h06,
    OCS_F_TRIP_A = 5'h07,
    OCS_F_TRIP_B = 5'h08,
    OCS_F_TRIP_C = 5'h09,
    OCS_F_START_AB = 5'h0A,
    OCS_F_START_BC = 5'h0B,
    OCS_F_START_CA = 5'h0C,
    OCS_F_START_ABC = 5'h0D,
    OCS_F_TRIP_AB = 5'h0E,
    OCS_F_TRIP_BC = 5'h0F,
    OCS_F_TRIP_CA = 5'h10,
    OCS_F_TRIP_ABC = 5'h11
  } ocs_force_t;

endpackage

//--- ocs_stage_if.sv
// settings of one stage as seen by its pick-up and timer logic
// assumes the top drives every field from its register file
`timescale 1ns/1ps
interface ocs_stage_if;
  logic [15:0] threshold;
  ocs_pkg::ocs_mag_t magSel;
  logic delayedRelease;
  logic resetAfterRelease;
  logic continueRelease;
  logic [15:0] releaseSteps;
  logic [15:0] opDelay;
  modport cfg (
    output threshold, magSel, delayedRelease, resetAfterRelease,
    output continueRelease, releaseSteps, opDelay
  );
  modport stage (
    input threshold, magSel, delayedRelease, resetAfterRelease,
    input continueRelease, releaseSteps, opDelay
  );
endinterface

//--- ocs_pickup.sv
// per-phase pick-up detector with 97 percent drop-out for one stage
// assumes magnitudes are updated together on measValid
`timescale 1ns/1ps
`include "ocs_cfg.svh"
module ocs_pickup (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic measValid,
  input wire logic [2:0][15:0] magRms,
  input wire logic [2:0][15:0] magTrms,
  input wire logic [2:0][15:0] magPp,
  ocs_stage_if.stage cfg,
  output logic [2:0] phasePick
);

  // each phase judged on its own against the common threshold
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gPhase
      logic [15:0] mag;
      logic [22:0] magScaled;
      logic [22:0] dropLevel;
      always_comb begin
        unique case (cfg.magSel)
          ocs_pkg::OCS_MAG_TRUE_ROOT_MEAN_SQUARE: mag = magTrms[g];
          ocs_pkg::OCS_MAG_PP: mag = magPp[g];
          default: mag = magRms[g];
        endcase
        magScaled = mag * `OCS_RATIO_BASE;
        dropLevel = cfg.threshold * `OCS_RESET_RATIO;
      end
      // hysteresis avoids chatter right at the threshold
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          phasePick[g] <= 1'b0;
        end else if (measValid) begin
          if (!phasePick[g] && mag > cfg.threshold) begin
            phasePick[g] <= 1'b1;
          end else if (phasePick[g] && magScaled < dropLevel) begin
            phasePick[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

endmodule

//--- ocs_stage_timer.sv
// start, release and operating time counter of one stage
// assumes tick is a one-cycle pulse once per program cycle
`timescale 1ns/1ps
`include "ocs_cfg.svh"
module ocs_stage_timer (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic tick,
  input wire logic pickAny,
  input wire logic blockIn,
  ocs_stage_if.stage cfg,
  output logic startLvl,
  output logic tripLvl,
  output logic blockedLvl,
  output logic [15:0] opCount
);

  ocs_pkg::ocs_tmr_st_t st_r;
  logic [15:0] relCnt_r;
  logic effPick;

  // a block arriving mid-start is handled like a pick-up drop
  assign effPick = pickAny & ~blockIn;

  // state and counters move only on the program cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= ocs_pkg::OCS_ST_IDLE;
      opCount <= 16'h0000;
      relCnt_r <= 16'h0000;
    end else if (tick) begin
      unique case (st_r)
        ocs_pkg::OCS_ST_IDLE, ocs_pkg::OCS_ST_BLOCKED: begin
          if (pickAny && blockIn) begin
            st_r <= ocs_pkg::OCS_ST_BLOCKED;
          end else if (effPick) begin
            st_r <= ocs_pkg::OCS_ST_RUN;
            opCount <= opCount + 16'h0001;
          end else begin
            st_r <= ocs_pkg::OCS_ST_IDLE;
          end
        end
        ocs_pkg::OCS_ST_RUN: begin
          if (effPick) begin
            if (opCount != 16'hFFFF) begin
              opCount <= opCount + 16'h0001;
            end
          end else begin
            st_r <= ocs_pkg::OCS_ST_RELEASE;
            relCnt_r <= 16'h0000;
            if (!cfg.resetAfterRelease) begin
              opCount <= 16'h0000;
            end
          end
        end
        ocs_pkg::OCS_ST_RELEASE: begin
          if (effPick) begin
            st_r <= ocs_pkg::OCS_ST_RUN;
            opCount <= opCount + 16'h0001;
          end else if (relCnt_r + 16'h0001 >= cfg.releaseSteps) begin
            st_r <= ocs_pkg::OCS_ST_IDLE;
            opCount <= 16'h0000;
          end else begin
            relCnt_r <= relCnt_r + 16'h0001;
            // held by default, wound back when continuing
            if (cfg.continueRelease && opCount != 16'h0000) begin
              opCount <= opCount - 16'h0001;
            end
          end
        end
      endcase
    end
  end

  // trip only from a live pick-up, never while releasing
  always_comb begin
    startLvl = (st_r == ocs_pkg::OCS_ST_RUN) ||
               (st_r == ocs_pkg::OCS_ST_RELEASE && cfg.delayedRelease);
    tripLvl = (st_r == ocs_pkg::OCS_ST_RUN) && (opCount >= cfg.opDelay);
    blockedLvl = (st_r == ocs_pkg::OCS_ST_BLOCKED);
  end

endmodule

//--- ocs_top.sv
// four-stage phase overcurrent start, release and trip timing with APB registers
// assumes synchronous measurement inputs and a local supervisory bus port
// What this block does
// - log-inverse, dial below 0.3, negative delay trips instantly
// - delayed release selects held or instant start reset
// - release delay in 5 ms steps, default 60 ms
// - start stays on while release timer runs
// - counter cleared when release time passes undisturbed
// - option off clears counter at pick-up drop
// - continue option winds counter back during release
// - no trip during release without renewed pick-up
// - default is 60 ms release, count held
// - global forcing drives each stage state directly
// - measured behaviour still acts while forcing is on
// - force selector defaults normal, only while forcing enabled
// - four independent stages on phase magnitude
// - one, two or three phases judged separately
// - magnitude select RMS, true RMS or peak-peak
// - bus permission gates supervisory pick-up level changes
// - general settings are static, no group switching
// - pick up above threshold, drop below 97 percent
// - block at pick-up gives blocked, no timing
`timescale 1ns/1ps
`include "ocs_cfg.svh"
module ocs_top #(
  parameter int TICK_CYCLES = `OCS_TICK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic measValid,
  input wire logic [15:0] phaseACurrentRms,
  input wire logic [15:0] phaseBCurrentRms,
  input wire logic [15:0] phaseCCurrentRms,
  input wire logic [15:0] phaseACurrentTrms,
  input wire logic [15:0] phaseBCurrentTrms,
  input wire logic [15:0] phaseCCurrentTrms,
  input wire logic [15:0] phaseACurrentPp,
  input wire logic [15:0] phaseBCurrentPp,
  input wire logic [15:0] phaseCCurrentPp,
  input wire logic [3:0] blockIn,
  input wire logic supWrite,
  input wire logic [1:0] supStage,
  input wire logic [15:0] supThreshold,
  output logic [3:0] stageStart,
  output logic [3:0] stageTrip,
  output logic [3:0] stageBlocked,
  output logic [11:0] phaseStart,
  output logic [11:0] phaseTrip
);

  // forced state bundle: start, trip, blocked, phase starts, phase trips
  function automatic logic [8:0] forceDecode(input logic [4:0] sel);
    logic [8:0] f;
    f = 9'h000;
    unique case (sel)
      ocs_pkg::OCS_F_START: f = 9'h100;
      ocs_pkg::OCS_F_TRIP: f = 9'h180;
      ocs_pkg::OCS_F_BLOCKED: f = 9'h040;
      ocs_pkg::OCS_F_START_A: f = 9'h108;
      ocs_pkg::OCS_F_START_B: f = 9'h110;
      ocs_pkg::OCS_F_START_C: f = 9'h120;
      ocs_pkg::OCS_F_TRIP_A: f = 9'h189;
      ocs_pkg::OCS_F_TRIP_B: f = 9'h192;
      ocs_pkg::OCS_F_TRIP_C: f = 9'h1A4;
      ocs_pkg::OCS_F_START_AB: f = 9'h118;
      ocs_pkg::OCS_F_START_BC: f = 9'h130;
      ocs_pkg::OCS_F_START_CA: f = 9'h128;
      ocs_pkg::OCS_F_START_ABC: f = 9'h138;
      ocs_pkg::OCS_F_TRIP_AB: f = 9'h19B;
      ocs_pkg::OCS_F_TRIP_BC: f = 9'h1B6;
      ocs_pkg::OCS_F_TRIP_CA: f = 9'h1AD;
      ocs_pkg::OCS_F_TRIP_ABC: f = 9'h1BF;
      default: f = 9'h000;
    endcase
    return f;
  endfunction

  logic [2:0][15:0] magRms;
  logic [2:0][15:0] magTrms;
  logic [2:0][15:0] magPp;
  logic [17:0] tickCnt_r;
  logic tick_r;
  logic forceEn_r;
  logic [31:0] ctrl_r [4];
  logic [15:0] thresh_r [4];
  logic [15:0] relSteps_r [4];
  logic [15:0] opDelay_r [4];
  logic [15:0] timeDial_r [4];
  logic [2:0] pick [4];
  logic [3:0] startLvl;
  logic [3:0] tripLvl;
  logic [3:0] blockedLvl;
  logic [15:0] opCount [4];
  logic [31:0] prdata_nxt;
  logic pslverr_nxt;
  logic setupPhase;
  logic wrStrobe;
  logic stageHit;
  logic [1:0] stageSel;

  // phase magnitudes grouped per measured quantity
  assign magRms = {phaseCCurrentRms, phaseBCurrentRms, phaseACurrentRms};
  assign magTrms = {phaseCCurrentTrms, phaseBCurrentTrms, phaseACurrentTrms};
  assign magPp = {phaseCCurrentPp, phaseBCurrentPp, phaseACurrentPp};

  // program cycle pulse, matched to the 5 ms measurement time base
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tickCnt_r <= 18'h0_0000;
      tick_r <= 1'b0;
    end else if (tickCnt_r == 18'(TICK_CYCLES - 1)) begin
      tickCnt_r <= 18'h0_0000;
      tick_r <= 1'b1;
    end else begin
      tickCnt_r <= tickCnt_r + 18'h0_0001;
      tick_r <= 1'b0;
    end
  end

  // apb decode: zero wait states, pready raised in the access cycle
  assign setupPhase = psel && !penable;
  assign wrStrobe = psel && penable && pready && pwrite && !pslverr;
  assign stageHit = !paddr[7] && (paddr[4:0] <= `OCS_REG_STATUS) && (paddr[1:0] == 2'b00);
  assign stageSel = paddr[6:5];

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setupPhase;
      pslverr <= setupPhase && pslverr_nxt;
      if (setupPhase) begin
        prdata <= prdata_nxt;
      end
    end
  end

  // global forcing enable; selector is cleared when forcing drops
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      forceEn_r <= 1'b0;
    end else if (wrStrobe && paddr == `OCS_REG_GLOBAL) begin
      forceEn_r <= pwdata[0];
    end
  end

  // four identical stages: registers, pick-up, timer, outputs
  genvar s;
  generate
    for (s = 0; s < 4; s++) begin : gStage
      ocs_stage_if sif ();
      logic hit;
      logic [8:0] forced;
      logic [4:0] forceSel;

      assign hit = wrStrobe && stageHit && (stageSel == 2'(s));
      assign forceSel = forceEn_r ? ctrl_r[s][`OCS_CTRL_FORCE_LSB +: 5] : 5'h00;

      // static settings: only bus writes change them, no group selection path
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          ctrl_r[s] <= `OCS_CTRL_RST;
          thresh_r[s] <= `OCS_THRESH_RST;
          relSteps_r[s] <= `OCS_REL_DELAY_RST;
          opDelay_r[s] <= `OCS_OPDELAY_RST;
          timeDial_r[s] <= `OCS_TIMEDIAL_RST;
        end else begin
          if (hit && paddr[4:0] == `OCS_REG_CTRL) begin
            ctrl_r[s] <= pwdata & `OCS_CTRL_MASK;
          end else if (!forceEn_r) begin
            ctrl_r[s][`OCS_CTRL_FORCE_LSB +: 5] <= 5'h00;
          end
          if (hit && paddr[4:0] == `OCS_REG_THRESH) begin
            thresh_r[s] <= pwdata[15:0];
          end else if (supWrite && supStage == 2'(s) && ctrl_r[s][`OCS_CTRL_BUS_ALLOW]) begin
            thresh_r[s] <= supThreshold;
          end
          if (hit && paddr[4:0] == `OCS_REG_RELEASE) begin
            relSteps_r[s] <= pwdata[15:0];
          end
          if (hit && paddr[4:0] == `OCS_REG_OPDELAY) begin
            opDelay_r[s] <= pwdata[15:0];
          end
          if (hit && paddr[4:0] == `OCS_REG_TIMEDIAL) begin
            timeDial_r[s] <= pwdata[15:0];
          end
        end
      end

      // negative delay: instant in the low-dial log-inverse case, otherwise the maximum FFFF-step delay
      always_comb begin
        sif.threshold = thresh_r[s];
        sif.magSel = ocs_pkg::ocs_mag_t'(ctrl_r[s][`OCS_CTRL_MAG_LSB +: 2]);
        sif.delayedRelease = ctrl_r[s][`OCS_CTRL_DLY_REL];
        sif.resetAfterRelease = ctrl_r[s][`OCS_CTRL_RST_AFTER];
        sif.continueRelease = ctrl_r[s][`OCS_CTRL_CONT];
        sif.releaseSteps = relSteps_r[s];
        if (!opDelay_r[s][15]) begin
          sif.opDelay = opDelay_r[s];
        end else if (ctrl_r[s][`OCS_CTRL_LOGINV] && timeDial_r[s] < `OCS_TIMEDIAL_MIN) begin
          sif.opDelay = 16'h0000;
        end else begin
          sif.opDelay = 16'hFFFF;
        end
      end

      ocs_pickup uPick (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .measValid(measValid),
        .magRms(magRms),
        .magTrms(magTrms),
        .magPp(magPp),
        .cfg(sif.stage),
        .phasePick(pick[s])
      );

      ocs_stage_timer uTmr (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .tick(tick_r),
        .pickAny(|pick[s]),
        .blockIn(blockIn[s]),
        .cfg(sif.stage),
        .startLvl(startLvl[s]),
        .tripLvl(tripLvl[s]),
        .blockedLvl(blockedLvl[s]),
        .opCount(opCount[s])
      );

      // forced states are ored over the measured ones, so injection still acts
      assign forced = forceDecode(forceSel);

      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          stageStart[s] <= 1'b0;
          stageTrip[s] <= 1'b0;
          stageBlocked[s] <= 1'b0;
          phaseStart[3*s +: 3] <= 3'h0;
          phaseTrip[3*s +: 3] <= 3'h0;
        end else begin
          stageStart[s] <= startLvl[s] | forced[8];
          stageTrip[s] <= tripLvl[s] | forced[7];
          stageBlocked[s] <= blockedLvl[s] | forced[6];
          phaseStart[3*s +: 3] <= ({3{startLvl[s]}} & pick[s]) | forced[5:3];
          phaseTrip[3*s +: 3] <= ({3{tripLvl[s]}} & pick[s]) | forced[2:0];
        end
      end
    end
  endgenerate

  // read mux; status shows the stage's own state and counter
  always_comb begin
    prdata_nxt = 32'h0000_0000;
    pslverr_nxt = 1'b0;
    if (paddr == `OCS_REG_GLOBAL) begin
      prdata_nxt = {31'h0000_0000, forceEn_r};
    end else if (!stageHit) begin
      pslverr_nxt = 1'b1;
    end else begin
      unique case (paddr[4:0])
        `OCS_REG_CTRL: prdata_nxt = ctrl_r[stageSel];
        `OCS_REG_THRESH: prdata_nxt = {16'h0000, thresh_r[stageSel]};
        `OCS_REG_RELEASE: prdata_nxt = {16'h0000, relSteps_r[stageSel]};
        `OCS_REG_OPDELAY: prdata_nxt = {16'h0000, opDelay_r[stageSel]};
        `OCS_REG_TIMEDIAL: prdata_nxt = {16'h0000, timeDial_r[stageSel]};
        default: prdata_nxt = {opCount[stageSel], 7'h00, 3'h0, pick[stageSel],
                               stageBlocked[stageSel], stageTrip[stageSel],
                               stageStart[stageSel]};
      endcase
    end
  end

endmodule

//--- ocs_top_checker.sv
// concurrent checks on the top-level ports of the stage timing block
// assumes stage 0 is never forced, stage 3 is held blocked, TICK_CYCLES >= 8
`timescale 1ns/1ps
module ocs_top_checker (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0] stageStart,
  input wire logic [3:0] stageTrip,
  input wire logic [3:0] stageBlocked,
  input wire logic [11:0] phaseTrip
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  // bus answers: wait-free, one-cycle ready, error only alongside ready
  ready_after_setup_a:
    assert property (psel && !penable |=> pready) else $error("ready missing after setup");
  ready_single_a:
    assert property (pready |=> !pready) else $error("ready held too long");
  error_with_ready_a:
    assert property (pslverr |-> pready) else $error("error without ready");
  // stage outputs
  blocked_excl_a:
    assert property (stageBlocked[3] |-> !stageStart[3]) else $error("blocked and start together");
  trip_needs_start_a:
    assert property (stageTrip[0] |-> stageStart[0]) else $error("trip without start");
  trip_after_start_a:
    assert property ($rose(stageTrip[0]) |-> $past(stageStart[0])) else $error("trip rose early");
  phase_trip_a:
    assert property (stageTrip[0] |-> |phaseTrip[2:0]) else $error("stage trip lacks phase");
  start_on_tick_a:
    assert property ($changed(stageStart[0]) |=> $stable(stageStart[0]) [*6])
      else $error("start moved between ticks");
endmodule

bind ocs_top ocs_top_checker chk (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .stageStart(stageStart),
  .stageTrip(stageTrip), .stageBlocked(stageBlocked), .phaseTrip(phaseTrip));

//--- ocs_meas_model.sv
// measurement front end: refreshes nine phase magnitudes once per program cycle
// assumes the bench sets target magnitudes; index 0-2 RMS, 3-5 true RMS, 6-8 peak-peak
`timescale 1ns/1ps
module ocs_meas_model #(
  parameter int TICK_CYCLES = 8
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [8:0][15:0] magSet,
  output logic measValid,
  output logic [8:0][15:0] magOut
);
  int cnt;
  // values change only with the valid pulse, so the stage never sees a half update
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 0;
      measValid <= 1'b0;
      magOut <= '0;
    end else begin
      measValid <= (cnt == TICK_CYCLES - 1);
      cnt <= (cnt == TICK_CYCLES - 1) ? 0 : cnt + 1;
      if (cnt == TICK_CYCLES - 1) begin
        magOut <= magSet;
      end
    end
  end
endmodule

//--- overcurrent_stage_release_timing_tb.sv
// self-checking bench for the stage timing block over its bus and measurement ports
// assumes the design answers bus requests wait-free and runs on a shortened tick
`timescale 1ns/1ps
module overcurrent_stage_release_timing_tb;
  localparam int TICK = 8;
  localparam int LIMIT = 20000;
  logic sys_clk, reset_n, psel, penable, pwrite, pready, pslverr, measValid, supWrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q, c1, c2;
  logic e;
  logic [8:0][15:0] magSet, mag;
  logic [3:0] blockLvl, stageStart, stageTrip, stageBlocked;
  logic [1:0] supStage;
  logic [15:0] supThreshold;
  logic [11:0] phaseStart, phaseTrip;
  int bad_count = 0, check_count = 0, cyc = 0;
  logic [31:0] relCtrl [4] = '{32'h0000_0006, 32'h0000_0002, 32'h0000_000E, 32'h0000_0004};
  logic [4:0] fcode [4] = '{5'h01, 5'h02, 5'h03, 5'h07};

  ocs_meas_model #(.TICK_CYCLES(TICK)) meas (.sys_clk(sys_clk), .reset_n(reset_n),
    .magSet(magSet), .measValid(measValid), .magOut(mag));
  ocs_top #(.TICK_CYCLES(TICK)) dut (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .measValid(measValid), .phaseACurrentRms(mag[0]),
    .phaseBCurrentRms(mag[1]), .phaseCCurrentRms(mag[2]), .phaseACurrentTrms(mag[3]),
    .phaseBCurrentTrms(mag[4]), .phaseCCurrentTrms(mag[5]), .phaseACurrentPp(mag[6]),
    .phaseBCurrentPp(mag[7]), .phaseCCurrentPp(mag[8]), .blockIn(blockLvl),
    .supWrite(supWrite), .supStage(supStage), .supThreshold(supThreshold),
    .stageStart(stageStart), .stageTrip(stageTrip), .stageBlocked(stageBlocked),
    .phaseStart(phaseStart), .phaseTrip(phaseTrip));

  // 40 MHz clock
  always #12.5 sys_clk = ~sys_clk;

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // hang guard: a stuck bus wait ends here as a mismatch
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // one bus transfer; an idle edge first keeps back-to-back calls from re-driving psel
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(q, exp);
  endtask

  task automatic ticks(input int n);
    repeat (n * TICK) @(posedge sys_clk);
  endtask

  task automatic sup_pulse();
    @(posedge sys_clk);
    supWrite <= 1'b1;
    @(posedge sys_clk);
    supWrite <= 1'b0;
  endtask

  // pick up, drop just under 97 percent, then sample status twice during release
  task automatic rel_case(input logic [31:0] ctrl);
    wr(8'h00, ctrl);
    magSet[0] <= 16'h0500;
    ticks(6);
    magSet[0] <= 16'h048B;
    ticks(3);
    apb(1'b0, 8'h14, 32'h0000_0000);
    c1 = q;
    // a delay already passed by the held or wound-back count must still not trip
    wr(8'h0C, 32'h0000_0001);
    ticks(2);
    apb(1'b0, 8'h14, 32'h0000_0000);
    c2 = q;
    wr(8'h0C, 32'h0000_0032);
    chk(c1[0], ctrl[1]);
    chk(c2[1], 1'b0);
    if (!ctrl[2]) chk(c1[31:16], 0);
    else if (ctrl[3]) chk(c2[31:16] < c1[31:16], 1'b1);
    else chk({c1[31:16] != 0, c2[31:16]}, {1'b1, c1[31:16]});
    ticks(14);
    rd(8'h14, 32'h0000_0000);
  endtask

  initial begin
    sys_clk = 1'b0;
    reset_n = 1'b0;
    {psel, penable, pwrite, supWrite} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    magSet = '0;
    blockLvl = 4'h8;
    supStage = 2'h2;
    supThreshold = 16'h1234;
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    // reset values
    for (int s = 0; s < 4; s++) rd(8'(s * 32), 32'h0000_0006);
    rd(8'h04, 32'h0000_04B0);
    rd(8'h08, 32'h0000_000C);
    rd(8'h0C, 32'h0000_0014);
    rd(8'h10, 32'h0000_0064);
    rd(8'h80, 32'h0000_0000);
    rd(8'h18, 32'h0000_0000);
    chk(e, 1'b1);
    // magnitude selection on stage 2; stage 0 stays on fundamental RMS
    for (int m = 1; m < 3; m++) begin
      wr(8'h40, 32'(m << 4));
      magSet[3 * m] <= 16'h0500;
      ticks(4);
      chk({stageStart[2], stageStart[0]}, 2'b10);
      magSet <= '0;
      ticks(4);
      chk(stageStart[2], 1'b0);
    end
    // supervisory threshold only when permitted
    sup_pulse();
    rd(8'h44, 32'h0000_04B0);
    wr(8'h40, 32'h0000_0040);
    sup_pulse();
    rd(8'h44, 32'h0000_1234);
    wr(8'h44, 32'h0000_04B0);
    // trip timing, negative delays, blocking
    wr(8'h0C, 32'h0000_0004);
    wr(8'h40, 32'h0000_0080);
    wr(8'h4C, 32'h0000_FFF0);
    wr(8'h50, 32'h0000_001D);
    wr(8'h20, 32'h0000_0080);
    wr(8'h2C, 32'h0000_FFF0);
    magSet[0] <= 16'h0500;
    ticks(10);
    chk({stageTrip[0], phaseTrip[0], phaseStart[2:0]}, 5'b11001);
    chk({stageTrip[2], stageTrip[1]}, 2'b10);
    chk({stageBlocked[3], stageStart[3]}, 2'b10);
    magSet[0] <= 16'h048D;
    ticks(3);
    chk(stageStart[0], 1'b1);
    wr(8'h0C, 32'h0000_0032);
    for (int i = 0; i < 4; i++) rel_case(relCtrl[i]);
    // forcing
    magSet[0] <= 16'h0000;
    wr(8'h20, 32'h0000_0200);
    rd(8'h20, 32'h0000_0000);
    wr(8'h80, 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      wr(8'h20, 32'(fcode[i]) << 8);
      repeat (3) @(posedge sys_clk);
      chk({phaseTrip[3], stageBlocked[1], stageTrip[1], stageStart[1]} >> (i > 2 ? 3 : i), 1);
    end
    wr(8'h20, 32'h0000_0000);
    magSet[0] <= 16'h0500;
    ticks(3);
    chk(stageStart[1], 1'b1);
    wr(8'h80, 32'h0000_0000);
    print_verdict();
  end
endmodule
